// ### hw/udc_pkg.sv
// Purpose: Constants and types for the four-digit up/down counter with display driver.
// Assumes: Single 20 MHz clock; all inputs synchronous to it.
// Notes: Shared by udc_counter and udc_scan.
// How it works
// - Decade variant: four BCD digits, up or down, presettable, maximum 9999.
// - Timing variant: four digits for time keeping, maximum 5959.
// - Separate presettable register compared with the counter continuously.
// - Equal output follows every match of counter and register.
// - Zero output from parallel detect across all four digits.
// - Carry/borrow pulse can clock a following identical counter.
// - Segment and BCD outputs come from output latches, not the counter.
// - Latches copy the counter only while the store control commands it.
// - Four digits scanned in turn, each a quarter period with its segments.
// - Leading zero digits can be blanked.
// - Internal free-running scan timer sequences the digits, no external clock.
// - Blanking control turns drivers off while counting continues.
// - BCD data moves digit by digit on a tri-state four-bit port.
// - Wrap 9999 to 0000 up, 0000 to 9999 down (5959 in the timing variant), pulse on wrap.
// - Zero output active low while counter holds 0000.
// - Equal output active low while counter and register match.
// - Select code: 00 latches only, 01 output, 10 preset counter, 11 register.
package udc_pkg;
   localparam int unsigned UDC_CLK_HZ = 20000000;
   localparam int unsigned UDC_SCAN_HZ = 10000;
   localparam int unsigned UDC_SCAN_TICKS = UDC_CLK_HZ / UDC_SCAN_HZ;
   localparam int UDC_DIGITS = 4;
   localparam logic [3:0] UDC_BCD_ZERO = 4'h0;
   localparam logic [3:0] UDC_DEC_MAX = 4'h9;
   localparam logic [3:0] UDC_TENS_MAX = 4'h5;
   localparam logic [3:0] UDC_BCD_ONE = 4'h1;
   localparam logic [6:0] UDC_SEG_OFF = 7'h00;
   localparam logic [3:0] UDC_DIG_OFF = 4'h0;

   typedef enum logic [1:0] {
      UDC_SEL_LATCH = 2'h0,
      UDC_SEL_OUTPUT = 2'h1,
      UDC_SEL_PRESET_CNT = 2'h2,
      UDC_SEL_PRESET_REG = 2'h3
   } udc_sel_t;

   typedef enum logic [1:0] {
      UDC_DISP_NORMAL = 2'h0,
      UDC_DISP_OFF = 2'h1,
      UDC_DISP_NO_LZB = 2'h2
   } udc_disp_t;

   typedef struct packed {
      logic store;
      logic up;
      udc_sel_t sel;
   } udc_ctrl_t;

   localparam udc_ctrl_t UDC_CTRL_RST = '{store: 1'b1, up: 1'b1, sel: UDC_SEL_LATCH};
endpackage : udc_pkg

// ### hw/udc_scan.sv
// Purpose: Free-running digit scan timer and digit index.
// Assumes: TICKS clock cycles per digit slot.
// Notes: Index advances 0..3, so each digit gets one quarter of the scan.
`timescale 1ns/1ps
`default_nettype none
module udc_scan #(
   parameter int unsigned TICKS = udc_pkg::UDC_SCAN_TICKS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Scan position
   output logic [1:0] idx,
   output logic step
);
   import udc_pkg::*;
   localparam int CW = $clog2(TICKS + 1);
   localparam logic [CW-1:0] LAST = CW'(TICKS - 1);

   generate
      if (TICKS < 1) begin : g_bad
         $error("udc_scan: TICKS must be at least 1");
      end
   endgenerate

   logic [CW-1:0] tick_q, tick_d;
   logic [1:0] idx_q, idx_d;
   logic step_d, step_q;

   always_comb begin
      step_d = (tick_q == LAST);
      tick_d = step_d ? '0 : tick_q + CW'(1);
      idx_d = step_d ? idx_q + 2'h1 : idx_q;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_q <= '0;
         idx_q <= 2'h0;
         step_q <= 1'b0;
      end else begin
         tick_q <= tick_d;
         idx_q <= idx_d;
         step_q <= step_d;
      end
   end

   assign idx = idx_q;
   assign step = step_q;
endmodule : udc_scan
`default_nettype wire

// ### hw/udc_counter.sv
// Purpose: Four-digit presettable up/down counter with compare register and display drive.
// Assumes: Count input and controller strobes synchronous to clk.
// Notes: TIMING_MODE 1 selects the 5959 time-keeping variant.
`timescale 1ns/1ps
`default_nettype none
module udc_counter #(
   parameter bit TIMING_MODE = 1'b0,
   parameter int unsigned SCAN_TICKS = udc_pkg::UDC_SCAN_TICKS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Count input
   input wire logic count_in,
   // Control word port
   input wire logic control_word_load_n,
   input wire logic cw_store,
   input wire logic cw_up,
   input wire udc_pkg::udc_sel_t transfer_select_code,
   input wire logic transfer_trigger_n,
   // Display mode
   input wire udc_pkg::udc_disp_t display_blank_control,
   // BCD port
   input wire logic [3:0] bcd_in,
   output logic [3:0] bcd_out,
   output logic bcd_oe,
   output logic [1:0] bcd_digit,
   // Status outputs
   output logic carry_borrow,
   output logic zero_n,
   output logic equal_n,
   // Display drive
   output logic [6:0] seg,
   output logic [3:0] digit_en
);
   import udc_pkg::*;

   generate
      if (SCAN_TICKS < 1) begin : g_bad
         $error("udc_counter: SCAN_TICKS must be at least 1");
      end
   endgenerate

   // Largest value of one digit position
   function automatic logic [3:0] dig_max(input int pos);
      dig_max = (TIMING_MODE && (pos % 2 == 1)) ? UDC_TENS_MAX : UDC_DEC_MAX;
   endfunction

   function automatic logic [6:0] seg_decode(input logic [3:0] v);
      unique case (v)
         4'h0: seg_decode = 7'h3F;
         4'h1: seg_decode = 7'h06;
         4'h2: seg_decode = 7'h5B;
         4'h3: seg_decode = 7'h4F;
         4'h4: seg_decode = 7'h66;
         4'h5: seg_decode = 7'h6D;
         4'h6: seg_decode = 7'h7D;
         4'h7: seg_decode = 7'h07;
         4'h8: seg_decode = 7'h7F;
         4'h9: seg_decode = 7'h6F;
         default: seg_decode = UDC_SEG_OFF;
      endcase
   endfunction

   logic [1:0] scan_idx;
   logic scan_step;

   udc_scan #(.TICKS(SCAN_TICKS)) u_scan (
      .clk(clk),
      .sys_rst(sys_rst),
      .idx(scan_idx),
      .step(scan_step)
   );

   udc_ctrl_t ctrl_q, ctrl_d;
   logic [3:0][3:0] cnt_q, cnt_d;
   logic [3:0][3:0] reg_q, reg_d;
   logic [3:0][3:0] lat_q, lat_d;
   logic count_prev_q, count_prev_d;
   logic cb_q, cb_d;
   logic zero_n_q, zero_n_d;
   logic equal_n_q, equal_n_d;
   logic [3:0] bcd_out_q, bcd_out_d;
   logic bcd_oe_q, bcd_oe_d;
   logic [1:0] bcd_digit_q, bcd_digit_d;
   logic [6:0] seg_q, seg_d;
   logic [3:0] digit_en_q, digit_en_d;

   logic xfer;
   logic rise;
   logic carry;
   logic lead_zero;

   // Counter, register, latches and status
   always_comb begin
      xfer = ~transfer_trigger_n;
      rise = count_in & ~count_prev_q;
      count_prev_d = count_in;
      ctrl_d = ctrl_q;
      cnt_d = cnt_q;
      reg_d = reg_q;
      lat_d = lat_q;
      cb_d = 1'b0;
      carry = 1'b0;
      if (!control_word_load_n) begin
         ctrl_d = '{store: cw_store, up: cw_up, sel: transfer_select_code};
      end
      if (xfer && ctrl_q.sel == UDC_SEL_PRESET_CNT) begin
         cnt_d[scan_idx] = bcd_in;
      end else if (rise) begin
         carry = 1'b1;
         for (int i = 0; i < UDC_DIGITS; i++) begin
            if (carry) begin
               if (ctrl_q.up) begin
                  if (cnt_q[i] >= dig_max(i)) begin
                     cnt_d[i] = UDC_BCD_ZERO;
                  end else begin
                     cnt_d[i] = cnt_q[i] + UDC_BCD_ONE;
                     carry = 1'b0;
                  end
               end else begin
                  if (cnt_q[i] == UDC_BCD_ZERO) begin
                     cnt_d[i] = dig_max(i);
                  end else begin
                     cnt_d[i] = cnt_q[i] - UDC_BCD_ONE;
                     carry = 1'b0;
                  end
               end
            end
         end
         cb_d = carry;
      end
      if (xfer && ctrl_q.sel == UDC_SEL_PRESET_REG) begin
         reg_d[scan_idx] = bcd_in;
      end
      if (ctrl_q.store) begin
         lat_d = cnt_q;
      end
      zero_n_d = (cnt_d != '0);
      equal_n_d = (cnt_d != reg_d);
   end

   // BCD port and display drive
   always_comb begin
      bcd_digit_d = scan_idx;
      bcd_oe_d = xfer && (ctrl_q.sel == UDC_SEL_OUTPUT);
      bcd_out_d = lat_q[scan_idx];
      lead_zero = (display_blank_control != UDC_DISP_NO_LZB) && (scan_idx != 2'h0);
      for (int i = 1; i < UDC_DIGITS; i++) begin
         if (2'(i) >= scan_idx && lat_q[i] != UDC_BCD_ZERO) begin
            lead_zero = 1'b0;
         end
      end
      if (display_blank_control == UDC_DISP_OFF) begin
         seg_d = UDC_SEG_OFF;
         digit_en_d = UDC_DIG_OFF;
      end else begin
         seg_d = lead_zero ? UDC_SEG_OFF : seg_decode(lat_q[scan_idx]);
         digit_en_d = 4'h1 << scan_idx;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= UDC_CTRL_RST;
         cnt_q <= '0;
         reg_q <= '0;
         lat_q <= '0;
         count_prev_q <= 1'b0;
         cb_q <= 1'b0;
         zero_n_q <= 1'b0;
         equal_n_q <= 1'b0;
         bcd_out_q <= 4'h0;
         bcd_oe_q <= 1'b0;
         bcd_digit_q <= 2'h0;
         seg_q <= UDC_SEG_OFF;
         digit_en_q <= UDC_DIG_OFF;
      end else begin
         ctrl_q <= ctrl_d;
         cnt_q <= cnt_d;
         reg_q <= reg_d;
         lat_q <= lat_d;
         count_prev_q <= count_prev_d;
         cb_q <= cb_d;
         zero_n_q <= zero_n_d;
         equal_n_q <= equal_n_d;
         bcd_out_q <= bcd_out_d;
         bcd_oe_q <= bcd_oe_d;
         bcd_digit_q <= bcd_digit_d;
         seg_q <= seg_d;
         digit_en_q <= digit_en_d;
      end
   end

   assign bcd_out = bcd_out_q;
   assign bcd_oe = bcd_oe_q;
   assign bcd_digit = bcd_digit_q;
   assign carry_borrow = cb_q;
   assign zero_n = zero_n_q;
   assign equal_n = equal_n_q;
   assign seg = seg_q;
   assign digit_en = digit_en_q;
endmodule : udc_counter
`default_nettype wire

// ### test/udc_counter_checker.sv
// Purpose: Port checks for udc_counter
// Assumes: One clock, sys_rst async high
// Notes: Bound below the module
`timescale 1ns/1ps
`default_nettype none
module udc_counter_checker #(
   parameter int unsigned SCAN_TICKS = 4
) (
   // Inputs
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic count_in,
   input wire logic transfer_trigger_n,
   input wire udc_pkg::udc_disp_t display_blank_control,
   // Outputs
   input wire logic bcd_oe,
   input wire logic [1:0] bcd_digit,
   input wire logic carry_borrow,
   input wire logic zero_n,
   input wire logic equal_n,
   input wire logic [6:0] seg,
   input wire logic [3:0] digit_en
);
   import udc_pkg::*;
   logic [1:0] dig_q;
   logic seen_q, seen_d, chg;
   int unsigned run_q, run_d;
   always_comb begin
      chg = bcd_digit != dig_q;
      seen_d = seen_q | chg;
      run_d = chg ? 1 : run_q + 1;
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dig_q <= 2'h0;
         seen_q <= 1'b0;
         run_q <= 0;
      end else begin
         dig_q <= bcd_digit;
         seen_q <= seen_d;
         run_q <= run_d;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   AST_CB_ONE: assert property (carry_borrow |=> !carry_borrow)
      else $error("carry too long");
   AST_CB_SRC: assert property (carry_borrow |-> $past(count_in) && !$past(count_in, 2))
      else $error("carry without count");
   AST_ONEHOT: assert property ($onehot0(digit_en))
      else $error("digits not one-hot");
   AST_BLANK: assert property ($past(display_blank_control) == UDC_DISP_OFF
      && $past(display_blank_control, 2) == UDC_DISP_OFF |-> {seg, digit_en} == 11'h000)
      else $error("display not blank");
   AST_DIG_STEP: assert property (chg |-> bcd_digit == dig_q + 2'h1)
      else $error("scan order");
   AST_DIG_TIME: assert property (seen_q && chg |-> run_q == SCAN_TICKS)
      else $error("scan slot length");
   AST_OE_OFF: assert property ($past(transfer_trigger_n) |-> !bcd_oe)
      else $error("port not released");
   AST_ZERO_SRC: assert property ($changed(zero_n) |-> $past(count_in)
      || !$past(transfer_trigger_n) || !$past(transfer_trigger_n, 2))
      else $error("zero moved alone");
   AST_EQ_SRC: assert property ($changed(equal_n) |-> $past(count_in)
      || !$past(transfer_trigger_n) || !$past(transfer_trigger_n, 2))
      else $error("equal moved alone");
   COV_WRAP: cover property (carry_borrow);
   COV_EQ: cover property ($fell(equal_n));
   COV_READ: cover property (bcd_oe ##1 bcd_oe);
endmodule : udc_counter_checker
bind udc_counter udc_counter_checker #(.SCAN_TICKS(SCAN_TICKS)) u_chk (.clk, .sys_rst,
   .count_in, .transfer_trigger_n, .display_blank_control, .bcd_oe, .bcd_digit,
   .carry_borrow, .zero_n, .equal_n, .seg, .digit_en);
`default_nettype wire

// ### test/udc_host_model.sv
// Purpose: Host side of the BCD port
// Assumes: Host drives the digit shown on bcd_digit
// Notes: Released lines toggle
`timescale 1ns/1ps
`default_nettype none
module udc_host_model (
   // Clock and request
   input wire logic clk,
   input wire logic host_en,
   input wire logic [15:0] host_val,
   // Device side
   input wire logic bcd_oe,
   input wire logic [3:0] bcd_out,
   input wire logic [1:0] bcd_digit,
   output logic [3:0] bcd_in
);
   logic [3:0] last_q = 4'h0;
   assign bcd_in = bcd_oe ? bcd_out : (host_en ? host_val[bcd_digit*4 +: 4] : ~last_q);
   always @(posedge clk) begin
      last_q <= bcd_in;
   end
endmodule : udc_host_model
`default_nettype wire

// ### test/test_four_digit_updown_counter_display.sv
// Purpose: Random and corner tests of udc_counter
// Assumes: Scan slot of 4 cycles
// Notes: uut is the decade variant, uut_time the time-keeping variant on the same inputs
`timescale 1ns/1ps
`default_nettype none
module test_four_digit_updown_counter_display;
   import udc_pkg::*;
   logic clk = 0, sys_rst = 1, count_in = 0, control_word_load_n = 1, cw_store = 1, cw_up = 1;
   logic transfer_trigger_n = 1, h_en = 0, bcd_oe, carry_borrow, zero_n, equal_n, c;
   udc_sel_t transfer_select_code = UDC_SEL_LATCH;
   udc_disp_t display_blank_control = UDC_DISP_NORMAL;
   logic [15:0] h_val = 16'h0000, v, e, r;
   logic [3:0] bcd_in, bcd_out, digit_en;
   logic [1:0] bcd_digit, d;
   logic t_oe, t_cb, t_zn, tc;
   logic [3:0] t_out;
   logic [15:0] rt;
   logic [6:0] seg;
   int fail_count = 0, n_checks = 0, cyc = 0, i, k;
   initial begin
      forever #25 clk = ~clk;
   end
   udc_counter #(.SCAN_TICKS(4)) uut (.clk, .sys_rst, .count_in, .control_word_load_n, .cw_store,
      .cw_up, .transfer_select_code, .transfer_trigger_n, .display_blank_control, .bcd_in,
      .bcd_out, .bcd_oe, .bcd_digit, .carry_borrow, .zero_n, .equal_n, .seg, .digit_en);
   udc_counter #(.TIMING_MODE(1'b1), .SCAN_TICKS(4)) uut_time (.clk, .sys_rst, .count_in,
      .control_word_load_n, .cw_store, .cw_up, .transfer_select_code, .transfer_trigger_n,
      .display_blank_control, .bcd_in, .bcd_out(t_out), .bcd_oe(t_oe), .bcd_digit(),
      .carry_borrow(t_cb), .zero_n(t_zn), .equal_n(), .seg(), .digit_en());
   udc_host_model host (.clk, .host_en(h_en), .host_val(h_val), .bcd_oe, .bcd_out, .bcd_digit,
      .bcd_in);
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
      n_checks++;
      if (s !== x) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, x, s);
      end
   endtask : chk
   // Control word, then a transfer held over one whole scan and more, ending past a slot's first edge
   task automatic xfer(input udc_sel_t s, input logic on);
      r = 'x;
      rt = 'x;
      @(negedge clk);
      control_word_load_n = 0;
      transfer_select_code = s;
      @(negedge clk);
      control_word_load_n = 1;
      transfer_trigger_n = 0;
      h_en = on;
      repeat (20) begin
         @(negedge clk);
         if (bcd_oe) r[bcd_digit*4 +: 4] = bcd_out;
         if (t_oe) rt[bcd_digit*4 +: 4] = t_out;
      end
      d = bcd_digit;
      for (k = 0; k < 9 && bcd_digit == d; k++) @(negedge clk);
      @(negedge clk);
      transfer_trigger_n = 1;
      h_en = 0;
   endtask : xfer
   task automatic cnt;
      @(negedge clk);
      count_in = 1;
      c = 0;
      tc = 0;
      repeat (3) begin
         @(negedge clk);
         count_in = 0;
         c |= carry_borrow;
         tc |= t_cb;
      end
   endtask : cnt
   task automatic dseg(input logic [3:0] de, input logic [6:0] x);
      for (k = 0; k < 20 && digit_en !== de; k++) @(negedge clk);
      chk("seg", {digit_en, seg}, {de, x});
   endtask : dseg
   function automatic logic [15:0] rnd;
      for (int j = 0; j < 4; j++) rnd[j*4 +: 4] = 4'($urandom % 10);
   endfunction : rnd
   function automatic logic [15:0] nxt(input logic [15:0] a, input logic u);
      logic w;
      w = 1;
      for (int j = 0; j < 4; j++) begin
         if (w) begin
            w = u ? a[j*4 +: 4] == 4'h9 : a[j*4 +: 4] == 4'h0;
            a[j*4 +: 4] = w ? (u ? 4'h0 : 4'h9) : (u ? a[j*4 +: 4] + 4'h1 : a[j*4 +: 4] - 4'h1);
         end
      end
      return a;
   endfunction : nxt
   initial begin
      void'($urandom(10752));
      repeat (8) @(negedge clk);
      sys_rst = 0;
      chk("zero_n", zero_n, 16'h0000);
      chk("equal_n", equal_n, 16'h0000);
      for (i = 0; i < 12; i++) begin
         v = i == 0 ? 16'h9999 : i == 1 ? 16'h0000 : i == 2 ? 16'h0001 : rnd();
         cw_up = i == 0 ? 1'b1 : i < 3 ? 1'b0 : 1'($urandom % 2);
         h_val = v;
         xfer(UDC_SEL_PRESET_CNT, 1);
         e = nxt(v, cw_up);
         h_val = i % 2 ? e : rnd();
         xfer(UDC_SEL_PRESET_REG, 1);
         cnt();
         chk("carry", c, (cw_up && v == 16'h9999) || (!cw_up && v == 16'h0000));
         chk("zero_n", zero_n, e != 16'h0000);
         chk("equal_n", equal_n, e != h_val);
         xfer(UDC_SEL_OUTPUT, 0);
         chk("latch", r, e);
         if (i < 3) begin
            chk("time carry", tc, i < 2);
            chk("time zero_n", t_zn, i == 1);
            chk("time latch", rt, i == 1 ? 16'h5959 : 16'h0000);
         end
      end
      // Store off must be in the control latch before the count
      cw_store = 0;
      xfer(UDC_SEL_LATCH, 0);
      cnt();
      xfer(UDC_SEL_OUTPUT, 0);
      chk("frozen", r, e);
      cw_store = 1;
      xfer(UDC_SEL_OUTPUT, 0);
      chk("stored", r, nxt(e, cw_up));
      h_val = 16'h0005;
      xfer(UDC_SEL_PRESET_CNT, 1);
      dseg(4'h8, 7'h00);
      dseg(4'h1, 7'h6D);
      display_blank_control = UDC_DISP_NO_LZB;
      dseg(4'h8, 7'h3F);
      display_blank_control = UDC_DISP_OFF;
      cnt();
      chk("blank", {digit_en, seg}, 16'h0000);
      display_blank_control = UDC_DISP_NORMAL;
      xfer(UDC_SEL_OUTPUT, 0);
      chk("count while off", r, nxt(16'h0005, cw_up));
      end_sim();
   end
endmodule : test_four_digit_updown_counter_display
`default_nettype wire
